// ===== amc_bus_ctl.sv
/*
 Behavioural two-wire bus controller facing the target block.
 Assumes the bench resolves both lines with pull-ups from every enable.
*/
`timescale 1ns/100ps
`default_nettype none

module amc_bus_ctl #(
  parameter int unsigned HALF_NS = 300
) (
  // controller owns the clock, only pulls low
  output logic scl_oe_out,
  output logic sda_oe_out,
  // Resolved data line
  input wire logic sda_in
);
  // Lines released at time zero
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end

  task automatic start_cond();
    #(HALF_NS / 2);
    sda_oe_out = 1'b0;
    #(HALF_NS / 2);
    scl_oe_out = 1'b0;
    #(HALF_NS);
    sda_oe_out = 1'b1;
    #(HALF_NS);
    scl_oe_out = 1'b1;
  endtask : start_cond

  task automatic stop_cond();
    #(HALF_NS / 2);
    sda_oe_out = 1'b1;
    #(HALF_NS / 2);
    scl_oe_out = 1'b0;
    #(HALF_NS);
    sda_oe_out = 1'b0;
    #(HALF_NS);
  endtask : stop_cond

  // data moves half-way through clock low
  task automatic bit_io(input logic b, output logic r);
    #(HALF_NS / 2);
    sda_oe_out = !b;
    #(HALF_NS / 2);
    scl_oe_out = 1'b0;
    #(HALF_NS / 2);
    r = sda_in;
    #(HALF_NS / 2);
    scl_oe_out = 1'b1;
  endtask : bit_io

  // eight bits then the acknowledge slot
  task automatic byte_io(input logic [7:0] b, input logic ack_bit, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ack_bit, a);
  endtask : byte_io
endmodule : amc_bus_ctl
`default_nettype wire

// ===== amc_mode_ctrl.sv
/*
 Converter mode control with a two-wire bus target front end.
 The link side runs on lnk_clk_in and samples the bus lines; the
 conversion sequencer runs on clk_in (50 MHz) and derives a 1 MHz tick.
 Assumes external pull-ups on the bus and an outside tri-state resolver.
*/
// Overview of operation
// - Reset loads default configuration, then powers down; bus stays alive.
// - General call with command 06h resets exactly like power-up.
// - Mode bit 1 means single-shot and powered down; this is the reset state.
// - While powered down the bus target still answers.
// - Start bit write powers up in 25 us, clears, runs one conversion.
// - Single-shot returns to power-down once the result is ready.
// - Start writes during a conversion are ignored.
// - Mode bit 0 converts continuously, next one starting at once.
// - New settings take effect from the next conversion onward.
// - Mode bit 1 or reset ends continuous operation into power-down.
// - Target only: never drives clock, drives data only when asked.
// - Lines are only pulled low or released, never driven high.
// - Bytes of eight bits; data changes with clock low, sampled high.
// - Bus idle over 25 ms mid-transfer abandons the transaction.
// - Data edge with clock high is START (falling) or STOP (rising).
// - Address byte holds 7-bit address and direction; only own address and general call answered.
// - Each byte is followed by an acknowledge slot.
// - Not-acknowledge leaves data high; foreign address gets no ack.
// - STOP idles the bus; START while active is a repeated start.
// - Select pin maps ground, supply, data, clock to four addresses.
// - Conversion time is one over data rate, timed by 1 MHz oscillator.
`timescale 1ns/100ps
`default_nettype none
`include "amc_params.svh"

module amc_mode_ctrl
  import amc_pkg::*;
#(
  parameter int unsigned LNK_HZ = `AMC_LNK_HZ,
  parameter int unsigned TMO_CYC = (`AMC_T_BUS_TIMEOUT_MS * (LNK_HZ / 1000)),
  parameter int unsigned FILT_LEN = 4,
  parameter int unsigned OSC_DIV = `AMC_OSC_DIV
) (
  // Core clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Link sampling clock
  input wire logic lnk_clk_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Address select strap: 0 ground, 1 supply, 2 data line, 3 clock line
  input wire logic [1:0] addr_sel_in,
  // Converter control
  output logic pwr_en_out,
  output logic conv_busy_out,
  output logic conv_done_out,
  output logic [2:0] conv_rate_out
);

  localparam int unsigned TW = $clog2(TMO_CYC + 1);
  localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);
  localparam logic [16:0] WAKE_LAST = 17'(`AMC_WAKE_CYC - 1);
  localparam amc_cfg_t CFG_RST = '{1'b0, `AMC_RST_RATE, `AMC_RST_MODE};

  // ****************************************************************
  // Link domain: reset and pin synchronisers
  // ****************************************************************
  logic lrst_s1_q;
  logic lrst_q;
  logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
  logic [1:0] asel_s1_q, asel_s2_q;
  logic [FILT_LEN-1:0] scl_h_q, sda_h_q;
  logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  logic busy_s1_q, busy_l_q;
  amc_lnk_regs_t ln_d, ln_q;
  amc_cnv_regs_t cv_d, cv_q;

  // Reset is brought in through two stages so the link side leaves it cleanly
  always_ff @(posedge lnk_clk_in) begin
    lrst_s1_q <= srst_in;
    lrst_q <= lrst_s1_q;
  end

  always_ff @(posedge lnk_clk_in) begin
    scl_s1_q <= scl_in;
    scl_s2_q <= scl_s1_q;
    sda_s1_q <= sda_in;
    sda_s2_q <= sda_s1_q;
    asel_s1_q <= addr_sel_in;
    asel_s2_q <= asel_s1_q;
    busy_s1_q <= cv_q.busy;
    busy_l_q <= busy_s1_q;
  end

  // Filtered level changes only after FILT_LEN equal samples
  logic scl_f_d, sda_f_d;
  always_comb begin
    scl_f_d = scl_f_q;
    sda_f_d = sda_f_q;
    if (&scl_h_q) begin
      scl_f_d = 1'b1;
    end else if (~|scl_h_q) begin
      scl_f_d = 1'b0;
    end
    if (&sda_h_q) begin
      sda_f_d = 1'b1;
    end else if (~|sda_h_q) begin
      sda_f_d = 1'b0;
    end
  end

  always_ff @(posedge lnk_clk_in) begin
    if (lrst_q) begin
      scl_h_q <= '1;
      sda_h_q <= '1;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_h_q <= {scl_h_q[FILT_LEN-2:0], scl_s2_q};
      sda_h_q <= {sda_h_q[FILT_LEN-2:0], sda_s2_q};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // ****************************************************************
  // Link domain: bus condition decode
  // ****************************************************************
  logic scl_rise, scl_fall, cond_start, cond_stop, any_edge;
  logic [6:0] own_addr;
  logic [7:0] status_byte;

  // conditions on data edges with clock high
  assign cond_start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign cond_stop = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  assign scl_rise = scl_f_q & ~scl_p_q;
  assign scl_fall = ~scl_f_q & scl_p_q;
  assign any_edge = (scl_f_q ^ scl_p_q) | (sda_f_q ^ sda_p_q);
  // strap picks the low two address bits, sampled every cycle
  assign own_addr = {`AMC_ADDR_BASE, asel_s2_q};
  // Start/status reads high when no conversion is under way
  assign status_byte = {~busy_l_q, 3'h0, ln_q.cfg.rate, ln_q.cfg.mode};

  // ****************************************************************
  // Link domain: target state machine
  // ****************************************************************
  logic [TW-1:0] tmo_d, tmo_q;

  always_comb begin
    ln_d = ln_q;
    tmo_d = tmo_q;
    // Idle timer restarts on any line movement
    if (any_edge || ln_q.st == LNK_IDLE) begin
      tmo_d = '0;
    end else begin
      tmo_d = tmo_q + TW'(1);
    end
    case (ln_q.st)
      LNK_IDLE: begin
        ln_d.sda_oe = 1'b0;
      end
      LNK_ADDR: begin
        if (scl_rise && ln_q.cnt < 4'h8) begin
          ln_d.sh = {ln_q.sh[6:0], sda_f_q};
          ln_d.cnt = ln_q.cnt + 4'h1;
        end else if (scl_fall && ln_q.cnt == 4'h8) begin
          // answer only own address or the general call
          if (ln_q.sh[7:1] == own_addr) begin
            ln_d.sda_oe = 1'b1;
            ln_d.rw = ln_q.sh[0];
            ln_d.gc = 1'b0;
            ln_d.st = LNK_AACK;
          end else if (ln_q.sh == `AMC_GC_ADDR) begin
            ln_d.sda_oe = 1'b1;
            ln_d.rw = 1'b0;
            ln_d.gc = 1'b1;
            ln_d.st = LNK_AACK;
          end else begin
            ln_d.st = LNK_IDLE;
          end
        end
      end
      LNK_AACK: begin
        if (scl_fall) begin
          ln_d.cnt = 4'h0;
          if (ln_q.rw) begin
            // data driven only for a controller read
            ln_d.sh = status_byte;
            ln_d.sda_oe = ~status_byte[7];
            ln_d.st = LNK_RTX;
          end else begin
            ln_d.sda_oe = 1'b0;
            ln_d.st = LNK_WRX;
          end
        end
      end
      LNK_WRX: begin
        if (scl_rise && ln_q.cnt < 4'h8) begin
          ln_d.sh = {ln_q.sh[6:0], sda_f_q};
          ln_d.cnt = ln_q.cnt + 4'h1;
        end else if (scl_fall && ln_q.cnt == 4'h8) begin
          ln_d.sda_oe = 1'b1;
          ln_d.st = LNK_WACK;
          if (ln_q.gc) begin
            if (ln_q.sh == `AMC_GC_RESET) begin
              ln_d.cfg = CFG_RST;
              ln_d.gc_tgl = ~ln_q.gc_tgl;
            end
          end else begin
            // control byte accepted in any power state
            ln_d.cfg.start = ln_q.sh[`AMC_FLD_START];
            ln_d.cfg.rate = ln_q.sh[`AMC_FLD_RATE_HI:`AMC_FLD_RATE_LO];
            ln_d.cfg.mode = ln_q.sh[`AMC_FLD_MODE];
            ln_d.wr_tgl = ~ln_q.wr_tgl;
          end
        end
      end
      LNK_WACK: begin
        if (scl_fall) begin
          ln_d.sda_oe = 1'b0;
          ln_d.cnt = 4'h0;
          ln_d.st = LNK_WRX;
        end
      end
      LNK_RTX: begin
        if (scl_rise) begin
          ln_d.cnt = ln_q.cnt + 4'h1;
        end else if (scl_fall) begin
          // next bit placed while clock is low
          if (ln_q.cnt == 4'h8) begin
            ln_d.sda_oe = 1'b0;
            ln_d.st = LNK_RACK;
          end else begin
            ln_d.sh = {ln_q.sh[6:0], 1'b0};
            ln_d.sda_oe = ~ln_q.sh[6];
          end
        end
      end
      LNK_RACK: begin
        if (scl_rise && sda_f_q) begin
          ln_d.st = LNK_IDLE;
        end else if (scl_fall) begin
          ln_d.sh = status_byte;
          ln_d.sda_oe = ~status_byte[7];
          ln_d.cnt = 4'h0;
          ln_d.st = LNK_RTX;
        end
      end
      default: begin
        ln_d.st = LNK_IDLE;
        ln_d.sda_oe = 1'b0;
      end
    endcase
    // repeated start reopens the address phase
    if (cond_start) begin
      ln_d.st = LNK_ADDR;
      ln_d.cnt = 4'h0;
      ln_d.sda_oe = 1'b0;
    end else if (cond_stop) begin
      ln_d.st = LNK_IDLE;
      ln_d.sda_oe = 1'b0;
    end else if (tmo_q >= TW'(TMO_CYC)) begin
      ln_d.st = LNK_IDLE;
      ln_d.sda_oe = 1'b0;
    end
  end

  // line only pulled low: data output held at zero
  always_ff @(posedge lnk_clk_in) begin
    if (lrst_q) begin
      ln_q <= '{LNK_IDLE, 4'h0, 8'h00, 1'b0, 1'b0, 1'b0, CFG_RST, 1'b0, 1'b0};
      tmo_q <= '0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      ln_q <= ln_d;
      tmo_q <= tmo_d;
      sda_out <= 1'b0;
      sda_oe_out <= ln_d.sda_oe;
    end
  end

  // ****************************************************************
  // Core domain: event crossings from the link
  // ****************************************************************
  logic [2:0] wr_sy_q, gc_sy_q;
  logic wr_ev, gc_ev;

  // Toggles cross in two stages; the third stage only feeds edge detect
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_sy_q <= 3'h0;
      gc_sy_q <= 3'h0;
    end else begin
      wr_sy_q <= {wr_sy_q[1:0], ln_q.wr_tgl};
      gc_sy_q <= {gc_sy_q[1:0], ln_q.gc_tgl};
    end
  end

  assign wr_ev = wr_sy_q[2] ^ wr_sy_q[1];
  assign gc_ev = gc_sy_q[2] ^ gc_sy_q[1];

  // ****************************************************************
  // Core domain: conversion sequencer
  // ****************************************************************
  logic osc_tick;
  logic start_req;
  logic [16:0] conv_last;

  // conversion length in oscillator periods for each rate code
  function automatic logic [16:0] conv_len(input logic [2:0] rate);
    case (rate)
      3'h0: conv_len = `AMC_CONV_R0;
      3'h1: conv_len = `AMC_CONV_R1;
      3'h2: conv_len = `AMC_CONV_R2;
      3'h3: conv_len = `AMC_CONV_R3;
      3'h4: conv_len = `AMC_CONV_R4;
      3'h5: conv_len = `AMC_CONV_R5;
      3'h6: conv_len = `AMC_CONV_R6;
      default: conv_len = `AMC_CONV_R7;
    endcase
  endfunction : conv_len

  // Config bus is quiet for many cycles around each toggle, so it is safe
  assign start_req = wr_ev & ln_q.cfg.start;
  assign osc_tick = (cv_q.div == OSC_LAST);
  assign conv_last = conv_len(cv_q.rate_run) - 17'h1;

  always_comb begin
    cv_d = cv_q;
    cv_d.done = 1'b0;
    cv_d.div = osc_tick ? 8'h00 : cv_q.div + 8'h01;
    if (wr_ev) begin
      cv_d.mode = ln_q.cfg.mode;
      cv_d.rate = ln_q.cfg.rate;
    end
    case (cv_q.st)
      CNV_PDN: begin
        // start from power-down; continuous mode starts on its own
        if (start_req || !cv_d.mode) begin
          cv_d.st = CNV_WAKE;
          cv_d.cnt = 17'h0;
        end
      end
      CNV_WAKE: begin
        if (cv_q.cnt == WAKE_LAST) begin
          cv_d.st = CNV_RUN;
          cv_d.cnt = 17'h0;
          cv_d.div = 8'h00;
          cv_d.rate_run = cv_d.rate;
        end else begin
          cv_d.cnt = cv_q.cnt + 17'h1;
        end
      end
      CNV_RUN: begin
        // start requests are not looked at here
        if (osc_tick) begin
          if (cv_q.cnt == conv_last) begin
            cv_d.done = 1'b1;
            cv_d.cnt = 17'h0;
            // settings picked up only at a conversion boundary
            cv_d.rate_run = cv_d.rate;
            // single-shot ends in power-down; mode 1 leaves continuous
            if (cv_d.mode) begin
              cv_d.st = CNV_PDN;
            end
          end else begin
            cv_d.cnt = cv_q.cnt + 17'h1;
          end
        end
      end
      default: begin
        cv_d.st = CNV_PDN;
      end
    endcase
    // general call reset behaves as power-up
    if (gc_ev) begin
      cv_d.st = CNV_PDN;
      cv_d.cnt = 17'h0;
      cv_d.mode = `AMC_RST_MODE;
      cv_d.rate = `AMC_RST_RATE;
      cv_d.rate_run = `AMC_RST_RATE;
      cv_d.done = 1'b0;
    end
    cv_d.pwr = (cv_d.st != CNV_PDN);
    cv_d.busy = (cv_d.st != CNV_PDN);
  end

  // defaults then power-down; single-shot mode after reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cv_q <= '{CNV_PDN, 17'h0, 8'h00, `AMC_RST_MODE, `AMC_RST_RATE,
                `AMC_RST_RATE, 1'b0, 1'b0, 1'b0};
    end else begin
      cv_q <= cv_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pwr_en_out = cv_q.pwr;
  assign conv_busy_out = cv_q.busy;
  assign conv_done_out = cv_q.done;
  assign conv_rate_out = cv_q.rate_run;

endmodule : amc_mode_ctrl
`default_nettype wire

// ===== amc_mode_ctrl_asserts.sv
/*
 Port-level checker for amc_mode_ctrl: bus drive, timeout and conversion timing.
 Assumes it is bound onto amc_mode_ctrl with TMO_CYC and OSC_DIV handed on.
*/
`timescale 1ns/100ps
`default_nettype none
`include "amc_params.svh"

module amc_mode_ctrl_asserts #(
  parameter int unsigned TMO_CYC = 2000,
  parameter int unsigned OSC_DIV = 50
) (
  // Clocks and reset
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic lnk_clk_in,
  // Bus pins and strap
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [1:0] addr_sel_in,
  // Converter control
  input wire logic pwr_en_out,
  input wire logic conv_busy_out,
  input wire logic conv_done_out,
  input wire logic [2:0] conv_rate_out
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic [31:0] conv_cnt_q, conv_cnt_d, idle_cnt_q, idle_cnt_d;
  logic scl_q, sda_q;

  // Cycles since power-up or the last result
  always_comb begin
    conv_cnt_d = (conv_busy_out && !conv_done_out) ? conv_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_in) begin
    conv_cnt_q <= srst_in ? 32'h0 : conv_cnt_d;
  end

  // Link cycles spent pulling data low with both lines frozen
  always_comb begin
    idle_cnt_d = (sda_oe_out && scl_in == scl_q && sda_in == sda_q) ? idle_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge lnk_clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    idle_cnt_q <= srst_in ? 32'h0 : idle_cnt_d;
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_one_pulse;
    conv_done_out ##1 !conv_done_out;
  endsequence

  // Wake stretch: powered, and no result can appear this early
  sequence s_wake_quiet;
    (pwr_en_out && !conv_done_out) [*8];
  endsequence

  a_sda_low_only: assert property (@(posedge lnk_clk_in) disable iff (srst_in)
    sda_out == 1'b0) else $error("data line driven high");
  a_oe_scl_low: assert property (@(posedge lnk_clk_in) disable iff (srst_in)
    $changed(sda_oe_out) |-> !scl_in) else $error("data drive changed with clock high");
  // Filter and sync delay give the release a few cycles of slack
  a_bus_timeout: assert property (@(posedge lnk_clk_in) disable iff (srst_in)
    idle_cnt_q <= TMO_CYC + 16) else $error("stalled bus not released");
  a_reset_defaults: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(srst_in) |-> !pwr_en_out && !conv_busy_out && conv_rate_out == 3'h4)
    else $error("reset state wrong");
  a_down_no_power: assert property (@(posedge clk_in) disable iff (srst_in)
    !conv_busy_out && !$past(conv_busy_out) |-> !pwr_en_out && !conv_done_out)
    else $error("activity while down");
  a_wake_powers: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(conv_busy_out) |-> s_wake_quiet) else $error("wake without power");
  a_done_single: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_done_out |-> s_one_pulse) else $error("result pulse too long");
  // Shortest conversion is the fastest rate; nothing may finish sooner
  a_conv_length: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_done_out |-> conv_cnt_q >= (`AMC_CONV_R7 - 1) * OSC_DIV)
    else $error("conversion too short");
endmodule : amc_mode_ctrl_asserts

bind amc_mode_ctrl amc_mode_ctrl_asserts #(.TMO_CYC(TMO_CYC), .OSC_DIV(OSC_DIV)) u_asserts (
  .clk_in(clk_in), .srst_in(srst_in), .lnk_clk_in(lnk_clk_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel_in),
  .pwr_en_out(pwr_en_out), .conv_busy_out(conv_busy_out), .conv_done_out(conv_done_out),
  .conv_rate_out(conv_rate_out)
);
`default_nettype wire

// ===== amc_mode_ctrl_tb_top.sv
/*
 Self-checking bench for amc_mode_ctrl, bus traffic through amc_bus_ctl.
 Assumes a 50 MHz core clock and a 15 ns link clock.
*/
`timescale 1ns/100ps
`default_nettype none

module amc_mode_ctrl_tb_top;
  // ****************************************************************
  // Clocks, wires and counters
  // ****************************************************************
  logic clk_in = 1'b0;
  logic lnk_clk = 1'b0;
  logic srst_in = 1'b1;
  logic [1:0] addr_sel = 2'h0;
  logic c_scl_oe, c_sda_oe, d_sda, d_oe, pwr_en, busy, done, ack;
  logic [2:0] rate;
  logic [7:0] rd;
  logic [1:0] acks;
  wire scl;
  wire sda;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_done = 0;
  int cyc = 0;

  // Phase-unrelated clocks
  always #10 clk_in = !clk_in;
  always #7.5 lnk_clk = !lnk_clk;
  assign scl = !c_scl_oe;
  assign sda = !(c_sda_oe || (d_oe && !d_sda));

  // Small timeout and divider keep the run short
  amc_mode_ctrl #(.TMO_CYC(2000), .OSC_DIV(2)) i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .lnk_clk_in(lnk_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(d_sda), .sda_oe_out(d_oe), .addr_sel_in(addr_sel), .pwr_en_out(pwr_en),
    .conv_busy_out(busy), .conv_done_out(done), .conv_rate_out(rate)
  );
  amc_bus_ctl i_ctl (.scl_oe_out(c_scl_oe), .sda_oe_out(c_sda_oe), .sda_in(sda));

  // Result pulses counted as they rise, ahead of any negedge poll; a hang ends the run
  always @(posedge done) n_done++;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Address byte then one control byte; bit set per acknowledge
  task xfer_wr(input logic [6:0] adr, input logic [7:0] d, output logic [1:0] a);
    logic [7:0] r;
    logic a0, a1;
    i_ctl.start_cond();
    i_ctl.byte_io({adr, 1'b0}, 1'b1, r, a0);
    i_ctl.byte_io(d, 1'b1, r, a1);
    i_ctl.stop_cond();
    a = {!a1, !a0};
  endtask : xfer_wr

  // Single status byte, refused by the controller to end the read
  task xfer_rd(input logic [6:0] adr, output logic [7:0] d, output logic a);
    logic [7:0] r;
    logic a1;
    i_ctl.start_cond();
    i_ctl.byte_io({adr, 1'b1}, 1'b1, r, a);
    i_ctl.byte_io(8'hFF, 1'b1, d, a1);
    i_ctl.stop_cond();
    a = !a;
  endtask : xfer_rd

  task wait_busy(input logic lvl);
    for (int i = 0; i < 30000 && busy !== lvl; i++) @(negedge clk_in);
  endtask : wait_busy

  task wait_done(input int n);
    for (int i = 0; i < 20000 && n_done < n; i++) @(negedge clk_in);
  endtask : wait_done

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_defaults();
    chk("busy", busy, 8'h0);
    chk("power", pwr_en, 8'h0);
    chk("rate", rate, 8'h4);
    xfer_rd(7'h48, rd, ack);
    chk("ack while down", ack, 8'h1);
    chk("status", rd, 8'h89);
    $display("test defaults ended");
  endtask : t_defaults

  task t_address();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_in) addr_sel <= 2'(s);
      repeat (20) @(posedge clk_in);
      xfer_wr(7'h48 + 7'(s), 8'h09, acks);
      chk("own address", acks, 8'h3);
      xfer_wr(7'h48 + 7'(s ^ 1), 8'h09, acks);
      chk("foreign address", acks, 8'h0);
    end
    @(posedge clk_in) addr_sel <= 2'h0;
    $display("test address ended");
  endtask : t_address

  task t_single();
    n_done = 0;
    xfer_wr(7'h48, 8'h8F, acks);
    wait_busy(1'b1);
    chk("woke", busy, 8'h1);
    xfer_wr(7'h48, 8'h8F, acks);
    wait_busy(1'b0);
    chk("down again", busy, 8'h0);
    chk("results", 8'(n_done), 8'h1);
    chk("rate used", rate, 8'h7);
    xfer_rd(7'h48, rd, ack);
    chk("status", rd, 8'h8F);
    $display("test single ended");
  endtask : t_single

  task t_cont();
    n_done = 0;
    xfer_wr(7'h48, 8'h0E, acks);
    wait_done(2);
    chk("still busy", busy, 8'h1);
    xfer_wr(7'h48, 8'h0C, acks);
    chk("old rate", rate, 8'h7);
    wait_done(n_done + 2);
    chk("new rate", rate, 8'h6);
    xfer_wr(7'h48, 8'h0D, acks);
    wait_busy(1'b0);
    chk("left continuous", busy, 8'h0);
    $display("test continuous ended");
  endtask : t_cont

  task t_gcall();
    xfer_wr(7'h48, 8'h0E, acks);
    wait_busy(1'b1);
    xfer_wr(7'h00, 8'h05, acks);
    chk("other call acks", acks, 8'h3);
    chk("other call ignored", busy, 8'h1);
    xfer_wr(7'h00, 8'h06, acks);
    chk("general call acks", acks, 8'h3);
    wait_busy(1'b0);
    chk("reset stops", busy, 8'h0);
    chk("reset rate", rate, 8'h4);
    xfer_rd(7'h48, rd, ack);
    chk("reset status", rd, 8'h89);
    $display("test general call ended");
  endtask : t_gcall

  // Controller stalls with the clock low inside the acknowledge
  task t_timeout();
    logic r;
    i_ctl.start_cond();
    // Address 48h with write bit: only bits 7 and 4 are ones
    for (int i = 7; i >= 0; i--) i_ctl.bit_io(i == 7 || i == 4, r);
    repeat (20) @(posedge clk_in);
    chk("ack drive", d_oe, 8'h1);
    repeat (1800) @(posedge clk_in);
    chk("released", d_oe, 8'h0);
    i_ctl.stop_cond();
    $display("test timeout ended");
  endtask : t_timeout

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    t_defaults();
    t_address();
    t_single();
    t_cont();
    t_gcall();
    t_timeout();
    give_verdict();
  end
endmodule : amc_mode_ctrl_tb_top
`default_nettype wire

// ===== amc_params.svh
/*
 Constants for the converter mode control and two-wire target block:
 addresses, reset values, control byte fields and timing figures.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// ****************************************************************
// Bus addressing
// ****************************************************************
`define AMC_ADDR_BASE 5'h12
`define AMC_GC_ADDR 8'h00
`define AMC_GC_RESET 8'h06

// ****************************************************************
// Control byte layout and reset values
// ****************************************************************
`define AMC_FLD_START 7
`define AMC_FLD_RATE_HI 3
`define AMC_FLD_RATE_LO 1
`define AMC_FLD_MODE 0
`define AMC_RST_MODE 1'h1
`define AMC_RST_RATE 3'h4

// ****************************************************************
// Timing
// ****************************************************************
`define AMC_CLK_HZ 50000000
`define AMC_OSC_HZ 1000000
`define AMC_T_WAKE_US 25
`define AMC_T_BUS_TIMEOUT_MS 25
`define AMC_LNK_HZ 66666666
`define AMC_WAKE_CYC ((`AMC_T_WAKE_US * `AMC_CLK_HZ) / 1000000)
`define AMC_OSC_DIV (`AMC_CLK_HZ / `AMC_OSC_HZ)

// Oscillator periods per conversion, one per data rate code
`define AMC_CONV_R0 17'h1E848
`define AMC_CONV_R1 17'h0F424
`define AMC_CONV_R2 17'h07A12
`define AMC_CONV_R3 17'h03D09
`define AMC_CONV_R4 17'h01E84
`define AMC_CONV_R5 17'h00FA0
`define AMC_CONV_R6 17'h00839
`define AMC_CONV_R7 17'h0048A

`endif

// ===== amc_pkg.sv
/*
 Types of the converter mode control block: state encodings and the
 packed records for configuration and link-side state.
 Assumes amc_params.svh is on the include path.
*/
`include "amc_params.svh"

package amc_pkg;

  // ****************************************************************
  // States
  // ****************************************************************
  typedef enum logic [2:0] {
    LNK_IDLE = 3'h0,
    LNK_ADDR = 3'h1,
    LNK_AACK = 3'h2,
    LNK_WRX = 3'h3,
    LNK_WACK = 3'h4,
    LNK_RTX = 3'h5,
    LNK_RACK = 3'h6
  } amc_lnk_state_t;

  typedef enum logic [1:0] {
    CNV_PDN = 2'h0,
    CNV_WAKE = 2'h1,
    CNV_RUN = 2'h2
  } amc_cnv_state_t;

  // ****************************************************************
  // Records
  // ****************************************************************
  typedef struct packed {
    logic start;
    logic [2:0] rate;
    logic mode;
  } amc_cfg_t;

  typedef struct packed {
    amc_lnk_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic gc;
    logic sda_oe;
    amc_cfg_t cfg;
    logic wr_tgl;
    logic gc_tgl;
  } amc_lnk_regs_t;

  typedef struct packed {
    amc_cnv_state_t st;
    logic [16:0] cnt;
    logic [7:0] div;
    logic mode;
    logic [2:0] rate;
    logic [2:0] rate_run;
    logic pwr;
    logic busy;
    logic done;
  } amc_cnv_regs_t;

endpackage : amc_pkg
